// *** rtl/intid_top.sv ***
// Interrupt identification register with its source groups,
// module gating and the system clock control register.
// Assumes one AHB-Lite master and events on the core clock.
//
// Summary of operation
// (R1) Any reset clears the identification register to zero.
// (R2) Identification register reads freely; writes change nothing.
// (R3) Bit 0 set only while a module 0 flag and its enable are set.
// (R4) Bit 0 drops when that source is disabled or its flag cleared.
// (R5) Bit 1 set only while a module 1 flag and its enable are set.
// (R6) Bit 1 drops when that source is disabled or its flag cleared.
// (R7) Bits 6 to 2 always read zero.
// (R8) Bit 7 set only while a system flag and its enable are set.
// (R9) Bit 7 drops when that source is disabled or its flag cleared.
// (R10) Any reset loads the clock control register with 60h.
// (R11) Clock control always readable; writes limited per bit.
// (R12) Module request needs global enable, module mask, not in service.
// (R13) Pending bits are the OR of flag AND enable, one clock late.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module intid_top
#(
  parameter int unsigned N0 = intid_pkg::SRC_N,
  parameter int unsigned N1 = intid_pkg::SRC_N,
  parameter int unsigned NS = intid_pkg::SRC_N
)
(
  input wire logic i_core_clk, // Core clock, 25 MHz
  input wire logic i_rst, // Sync reset, active high
  input wire logic i_hsel, // AHB slave select
  input wire logic [31:0] i_haddr, // AHB address
  input wire logic [1:0] i_htrans, // AHB transfer type
  input wire logic i_hwrite, // AHB write
  input wire logic [2:0] i_hsize, // AHB size
  input wire logic i_hready, // AHB ready
  input wire logic [31:0] i_hwdata, // AHB write data
  output logic o_hreadyout, // AHB slave ready
  output logic o_hresp, // AHB response
  output logic [31:0] o_hrdata, // AHB read data
  input wire logic [N0-1:0] i_mod0_event, // Module 0 source events
  input wire logic [N1-1:0] i_mod1_event, // Module 1 source events
  input wire logic [NS-1:0] i_sys_event, // System source events
  output logic [2:0] o_irq_req, // Requests: sys, mod1, mod0
  output logic o_irq, // Any unmasked request
  output logic [7:0] o_clk_ctl, // Clock control value
  output logic o_stop // Stop request
);

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  logic wr_en;
  logic [intid_pkg::AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  ahb_word_slave u_bus
  (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hready(i_hready),
    .i_hwdata(i_hwdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .o_wr_en(wr_en),
    .o_addr(addr),
    .o_wdata(wdata),
    .i_rdata(rdata)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire hit_summary = (addr == intid_pkg::ADDR_SUMMARY);
  wire hit_clkctl = (addr == intid_pkg::ADDR_CLKCTL);
  wire hit_flag0 = (addr == intid_pkg::ADDR_FLAG0);
  wire hit_en0 = (addr == intid_pkg::ADDR_EN0);
  wire hit_flag1 = (addr == intid_pkg::ADDR_FLAG1);
  wire hit_en1 = (addr == intid_pkg::ADDR_EN1);
  wire hit_flags = (addr == intid_pkg::ADDR_FLAGS);
  wire hit_ens = (addr == intid_pkg::ADDR_ENS);
  wire hit_ctrl = (addr == intid_pkg::ADDR_CTRL);

  wire wr_clkctl = wr_en && hit_clkctl;
  wire wr_ctrl = wr_en && hit_ctrl;

  // ----------------------------------------
  // Source groups
  // ----------------------------------------
  logic [N0-1:0] flags0;
  logic [N0-1:0] en0;
  logic [N1-1:0] flags1;
  logic [N1-1:0] en1;
  logic [NS-1:0] flags_s;
  logic [NS-1:0] en_s;
  logic pend0;
  logic pend1;
  logic pend_s;

  source_group #(.N(N0)) u_mod0
  (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_event(i_mod0_event),
    .i_flag_wr(wr_en && hit_flag0),
    .i_en_wr(wr_en && hit_en0),
    .i_wdata(wdata[N0-1:0]),
    .o_flags(flags0),
    .o_enables(en0),
    .o_pending(pend0)
  );

  source_group #(.N(N1)) u_mod1
  (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_event(i_mod1_event),
    .i_flag_wr(wr_en && hit_flag1),
    .i_en_wr(wr_en && hit_en1),
    .i_wdata(wdata[N1-1:0]),
    .o_flags(flags1),
    .o_enables(en1),
    .o_pending(pend1)
  );

  source_group #(.N(NS)) u_sys
  (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_event(i_sys_event),
    .i_flag_wr(wr_en && hit_flags),
    .i_en_wr(wr_en && hit_ens),
    .i_wdata(wdata[NS-1:0]),
    .o_flags(flags_s),
    .o_enables(en_s),
    .o_pending(pend_s)
  );

  // ----------------------------------------
  // Identification register
  // ----------------------------------------
  // No write path at all, so bus writes cannot disturb it
  logic [7:0] summary_q;
  logic [7:0] summary_d;

  always_comb
  begin
    summary_d = intid_pkg::SUMMARY_RST; // [R7]
    summary_d[intid_pkg::PEND_M0] = pend0; // [R3] [R4]
    summary_d[intid_pkg::PEND_M1] = pend1; // [R5] [R6]
    summary_d[intid_pkg::PEND_SYS] = pend_s; // [R8] [R9]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      summary_q <= intid_pkg::SUMMARY_RST; // [R1]
    else
      summary_q <= summary_d; // [R2] [R13]
  end

  // ----------------------------------------
  // Module gating control
  // ----------------------------------------
  // System module mask is fixed at one
  logic [8:0] ctrl_q;
  logic [8:0] ctrl_wr;

  assign ctrl_wr = (wdata[8:0] & intid_pkg::CTRL_WR_MASK) | intid_pkg::CTRL_RST;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      ctrl_q <= intid_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= ctrl_wr;
  end

  wire global_interrupt_enable = ctrl_q[intid_pkg::CTRL_GE];
  wire interrupt_in_service = ctrl_q[intid_pkg::CTRL_INS];
  wire module0_mask = ctrl_q[intid_pkg::CTRL_MASK0];
  wire module1_mask = ctrl_q[intid_pkg::CTRL_MASK1];
  wire system_mask = ctrl_q[intid_pkg::CTRL_MASKS];
  wire gate_open = global_interrupt_enable && !interrupt_in_service;

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  wire req0 = gate_open && module0_mask && summary_q[intid_pkg::PEND_M0]; // [R12]
  wire req1 = gate_open && module1_mask && summary_q[intid_pkg::PEND_M1]; // [R12]
  wire req_s = gate_open && system_mask && summary_q[intid_pkg::PEND_SYS]; // [R12]

  assign o_irq_req = {req_s, req1, req0};
  assign o_irq = |o_irq_req;

  // ----------------------------------------
  // System clock control
  // ----------------------------------------
  // Bits 6:5 hold ones; stop drops on any enabled request
  logic [7:0] clkctl_q;
  logic [7:0] clkctl_d;
  logic [7:0] clkctl_wr;

  assign clkctl_wr = (wdata[7:0] & intid_pkg::CLKCTL_WR_MASK) | intid_pkg::CLKCTL_RO_ONES;

  always_comb
  begin
    clkctl_d = wr_clkctl ? clkctl_wr : clkctl_q; // [R11]
    if (o_irq)
      clkctl_d[intid_pkg::CLKCTL_STOP] = 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      clkctl_q <= intid_pkg::CLKCTL_RST; // [R10]
    else
      clkctl_q <= clkctl_d;
  end

  assign o_clk_ctl = clkctl_q;
  assign o_stop = clkctl_q[intid_pkg::CLKCTL_STOP];

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  // Unmapped addresses read zero with an OKAY answer
  wire [31:0] rd_summary = {24'h0, summary_q}; // [R2]
  wire [31:0] rd_clkctl = {24'h0, clkctl_q}; // [R11]
  wire [31:0] rd_flag0 = 32'(flags0);
  wire [31:0] rd_en0 = 32'(en0);
  wire [31:0] rd_flag1 = 32'(flags1);
  wire [31:0] rd_en1 = 32'(en1);
  wire [31:0] rd_flags = 32'(flags_s);
  wire [31:0] rd_ens = 32'(en_s);
  wire [31:0] rd_ctrl = {23'h0, ctrl_q};

  assign rdata = hit_summary ? rd_summary :
                 hit_clkctl ? rd_clkctl :
                 hit_flag0 ? rd_flag0 :
                 hit_en0 ? rd_en0 :
                 hit_flag1 ? rd_flag1 :
                 hit_en1 ? rd_en1 :
                 hit_flags ? rd_flags :
                 hit_ens ? rd_ens :
                 hit_ctrl ? rd_ctrl :
                 32'h0;

endmodule
`default_nettype wire

// *** rtl/intid_pkg.sv ***
// Constants shared by the interrupt identification block.
// Assumes a 32-bit AHB-Lite bus with word registers.
package intid_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned SRC_N = 4;
  localparam int unsigned AW = 12;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0] IDX_SUMMARY = 8'h0b;
  localparam logic [7:0] IDX_CLKCTL = 8'h0e;
  localparam logic [AW-1:0] ADDR_SUMMARY = {2'h0, IDX_SUMMARY, 2'h0};
  localparam logic [AW-1:0] ADDR_CLKCTL = {2'h0, IDX_CLKCTL, 2'h0};
  localparam logic [AW-1:0] ADDR_FLAG0 = 12'h040;
  localparam logic [AW-1:0] ADDR_EN0 = 12'h044;
  localparam logic [AW-1:0] ADDR_FLAG1 = 12'h048;
  localparam logic [AW-1:0] ADDR_EN1 = 12'h04c;
  localparam logic [AW-1:0] ADDR_FLAGS = 12'h050;
  localparam logic [AW-1:0] ADDR_ENS = 12'h054;
  localparam logic [AW-1:0] ADDR_CTRL = 12'h058;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned PEND_M0 = 0;
  localparam int unsigned PEND_M1 = 1;
  localparam int unsigned PEND_SYS = 7;
  localparam logic [7:0] SUMMARY_RST = 8'h00;
  localparam logic [7:0] CLKCTL_RST = 8'h60;
  localparam logic [7:0] CLKCTL_RO_ONES = 8'h60;
  localparam logic [7:0] CLKCTL_WR_MASK = 8'h9f;
  localparam int unsigned CLKCTL_STOP = 4;
  localparam int unsigned CTRL_GE = 0;
  localparam int unsigned CTRL_MASK0 = 1;
  localparam int unsigned CTRL_MASK1 = 2;
  localparam int unsigned CTRL_MASKS = 7;
  localparam int unsigned CTRL_INS = 8;
  localparam logic [8:0] CTRL_RST = 9'h080;
  localparam logic [8:0] CTRL_WR_MASK = 9'h107;

  // ----------------------------------------
  // Bus
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_WAIT = 2'h1,
    PH_DONE = 2'h3
  } bus_phase_t;

endpackage

// *** rtl/ahb_word_slave.sv ***
// AHB-Lite slave front end: one wait state, word registers.
// Assumes it is the only slave; core answers reads combinationally.
`timescale 1ns/1ps
`default_nettype none
module ahb_word_slave
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Sync reset, active high
  input wire logic i_hsel, // Slave select
  input wire logic [31:0] i_haddr, // Address
  input wire logic [1:0] i_htrans, // Transfer type
  input wire logic i_hwrite, // Write when high
  input wire logic [2:0] i_hsize, // Ignored, words only
  input wire logic i_hready, // Bus ready
  input wire logic [31:0] i_hwdata, // Write data
  output logic o_hreadyout, // Slave ready
  output logic o_hresp, // Always OKAY
  output logic [31:0] o_hrdata, // Read data
  output logic o_wr_en, // Write strobe to core
  output logic [intid_pkg::AW-1:0] o_addr, // Latched address
  output logic [31:0] o_wdata, // Write data to core
  input wire logic [31:0] i_rdata // Read data from core
);

  intid_pkg::bus_phase_t state_q;
  intid_pkg::bus_phase_t state_d;
  logic write_q;
  logic [intid_pkg::AW-1:0] addr_q;
  logic [31:0] hrdata_q;
  logic accept;
  logic in_wait;

  assign accept = i_hsel && i_hready && (i_htrans == intid_pkg::HTRANS_NONSEQ);
  assign in_wait = (state_q == intid_pkg::PH_WAIT);

  always_comb
  begin
    unique case (state_q)
      intid_pkg::PH_WAIT: state_d = intid_pkg::PH_DONE;
      default: state_d = accept ? intid_pkg::PH_WAIT : intid_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_q <= intid_pkg::PH_IDLE;
      write_q <= 1'b0;
      addr_q <= '0;
      hrdata_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (accept && !in_wait)
      begin
        write_q <= i_hwrite;
        addr_q <= i_haddr[intid_pkg::AW-1:0];
      end
      // Read data sampled in the wait cycle, shown in the done cycle
      if (in_wait)
        hrdata_q <= write_q ? 32'h0 : i_rdata;
    end
  end

  assign o_hreadyout = !in_wait;
  assign o_hresp = intid_pkg::HRESP_OKAY;
  assign o_hrdata = hrdata_q;
  assign o_wr_en = in_wait && write_q;
  assign o_addr = addr_q;
  assign o_wdata = i_hwdata;

endmodule
`default_nettype wire

// *** rtl/source_group.sv ***
// Flags and enables of one interrupt module's sources.
// Assumes events are single-cycle pulses from core-clock logic.
`timescale 1ns/1ps
`default_nettype none
module source_group
#(
  parameter int unsigned N = 4
)
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Sync reset, active high
  input wire logic [N-1:0] i_event, // Source events
  input wire logic i_flag_wr, // Write-one-to-clear strobe
  input wire logic i_en_wr, // Enable write strobe
  input wire logic [N-1:0] i_wdata, // Write data
  output logic [N-1:0] o_flags, // Sticky flags
  output logic [N-1:0] o_enables, // Source enables
  output logic o_pending // Some enabled flag set
);

  logic [N-1:0] flags_q;
  logic [N-1:0] flags_d;
  logic [N-1:0] en_q;
  logic [N-1:0] clr;

  assign clr = i_flag_wr ? i_wdata : '0;
  // Set wins over a clear in the same cycle
  assign flags_d = (flags_q & ~clr) | i_event;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      flags_q <= '0;
      en_q <= '0;
    end
    else
    begin
      flags_q <= flags_d;
      if (i_en_wr)
        en_q <= i_wdata;
    end
  end

  assign o_flags = flags_q;
  assign o_enables = en_q;
  assign o_pending = |(flags_q & en_q); // [R13]

endmodule
`default_nettype wire

// *** dv/intid_monitor.sv ***
// Port checker for the interrupt identification block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module intid_monitor
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Sync reset
  input wire logic i_hsel, // Select
  input wire logic [31:0] i_haddr, // Address
  input wire logic [1:0] i_htrans, // Transfer type
  input wire logic i_hwrite, // Write
  input wire logic i_hready, // Ready in
  input wire logic o_hreadyout, // Ready out
  input wire logic o_hresp, // Response
  input wire logic [31:0] o_hrdata, // Read data
  input wire logic [2:0] o_irq_req, // Requests
  input wire logic o_irq, // Interrupt
  input wire logic [7:0] o_clk_ctl, // Clock control
  input wire logic o_stop // Stop request
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire logic take = i_hsel && i_hready && i_htrans == intid_pkg::HTRANS_NONSEQ;
  wire logic rd_sum = take && !i_hwrite && i_haddr[11:0] == intid_pkg::ADDR_SUMMARY;
  wire logic wr_ck = take && i_hwrite && i_haddr[11:0] == intid_pkg::ADDR_CLKCTL;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_reset;
    disable iff (1'b0) i_rst |=> o_clk_ctl == intid_pkg::CLKCTL_RST && o_irq_req == 3'h0
      && !o_irq && o_hrdata == 32'h0;
  endproperty
  property p_wait;
    take |=> !o_hreadyout ##1 o_hreadyout;
  endproperty
  property p_okay;
    o_hresp == intid_pkg::HRESP_OKAY;
  endproperty
  property p_rsvd;
    rd_sum |=> ##1 o_hrdata[31:8] == 24'h0 && o_hrdata[6:2] == 5'h0;
  endproperty
  property p_ones;
    o_clk_ctl[6:5] == 2'h3;
  endproperty
  // Stop may only rise from a clock control write, two edges after its address phase
  property p_stopbit;
    o_stop == o_clk_ctl[4] && (!$rose(o_stop) || $past(wr_ck, 2));
  endproperty
  property p_irq_or;
    o_irq == |o_irq_req;
  endproperty
  property p_irq_stop;
    o_irq |=> !o_stop;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  a_wait: assert property (p_wait) else $error("not one wait state");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  a_ones: assert property (p_ones) else $error("fixed ones lost");
  a_stopbit: assert property (p_stopbit) else $error("stop mismatch");
  a_irq_or: assert property (p_irq_or) else $error("irq not or of requests");
  a_irq_stop: assert property (p_irq_stop) else $error("stop not cleared");
  c_rd_sum: cover property (rd_sum);
  c_irq: cover property (o_irq);
  c_stop: cover property (o_stop);
endmodule
bind intid_top intid_monitor intid_monitor_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
  .o_irq_req(o_irq_req), .o_irq(o_irq), .o_clk_ctl(o_clk_ctl), .o_stop(o_stop));
`default_nettype wire

// *** dv/tb_intid_top.sv ***
// Self-checking bench for the identification block.
// Assumes the default source counts and a single bus master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module tb_intid_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ev0 = 4'h0;
  logic [3:0] ev1 = 4'h0;
  logic [3:0] evs = 4'h0;
  wire logic hrdy;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [2:0] irq_req;
  wire logic irq;
  wire logic [7:0] clkctl;
  wire logic stop;
  logic rdy_s;
  logic [31:0] rdat_s;
  logic [31:0] d;
  logic [31:0] r;
  logic [31:0] seed = 32'h05bc38c8;
  logic [3:0] fl [3];
  logic [3:0] en [3];
  logic [8:0] ctl;
  logic [11:0] fa [3] = '{intid_pkg::ADDR_FLAG0, intid_pkg::ADDR_FLAG1, intid_pkg::ADDR_FLAGS};
  int mismatches = 0;
  int compares = 0;

  intid_top intid_top_i (.i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hrdy),
    .i_hwdata(hwdata), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_mod0_event(ev0), .i_mod1_event(ev1), .i_sys_event(evs), .o_irq_req(irq_req),
    .o_irq(irq), .o_clk_ctl(clkctl), .o_stop(stop));

  initial
  begin
    forever #20 clk = ~clk;
  end
  // Ready and data only move at rising edges, so the falling edge gives a race-free sample
  always @(negedge clk)
  begin
    rdy_s = hrdy;
    rdat_s = hrdata;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wt();
    int n;
    n = 0;
    @(posedge clk);
    while (rdy_s !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 20)
      `CHK(1'b0, 1'b1)
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= intid_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt();
    rd = rdat_s;
  endtask
  task automatic pulse(input logic [11:0] v);
    ev0 <= v[3:0];
    ev1 <= v[7:4];
    evs <= v[11:8];
    @(posedge clk);
    ev0 <= 4'h0;
    ev1 <= 4'h0;
    evs <= 4'h0;
    for (int g = 0; g < 3; g++)
      fl[g] |= v[4*g+:4];
    @(posedge clk);
  endtask
  task automatic chk();
    logic [2:0] p;
    p = {|(fl[2] & en[2]) & ctl[7], |(fl[1] & en[1]) & ctl[2], |(fl[0] & en[0]) & ctl[1]};
    p &= {3{ctl[0] & ~ctl[8]}};
    bus(1'b0, intid_pkg::ADDR_SUMMARY, 32'h0, d);
    `CHK(d, {24'h0, |(fl[2] & en[2]), 5'h0, |(fl[1] & en[1]), |(fl[0] & en[0])})
    #1;
    `CHK(irq_req, p)
    `CHK(irq, |p)
  endtask
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    fl = '{default: 4'h0};
    en = '{default: 4'h0};
    ctl = intid_pkg::CTRL_RST;
    @(posedge clk);
    chk();
    bus(1'b0, intid_pkg::ADDR_CLKCTL, 32'h0, d);
    `CHK(d, 32'h60)
    bus(1'b0, intid_pkg::ADDR_CTRL, 32'h0, d);
    `CHK(d, 32'h80)
    $display("reset test done");
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    reset_dut();
    bus(1'b1, intid_pkg::ADDR_SUMMARY, 32'hffffffff, d);
    chk();
    bus(1'b0, 12'hffc, 32'h0, d);
    `CHK(d, 32'h0)
    bus(1'b1, intid_pkg::ADDR_CLKCTL, 32'hffffffff, d);
    bus(1'b0, intid_pkg::ADDR_CLKCTL, 32'h0, d);
    `CHK(d, 32'hff)
    `CHK(stop, 1'b1)
    `CHK(clkctl, 8'hff)
    $display("write test done");
    for (int i = 0; i < 15; i++)
    begin
      r = rnd();
      for (int g = 0; g < 3; g++)
      begin
        en[g] = r[4*g+:4];
        bus(1'b1, fa[g] + 12'h4, {28'h0, en[g]}, d);
      end
      ctl = (r[20:12] & intid_pkg::CTRL_WR_MASK) | intid_pkg::CTRL_RST;
      bus(1'b1, intid_pkg::ADDR_CTRL, {23'h0, r[20:12]}, d);
      r = rnd();
      pulse(r[11:0]);
      chk();
      bus(1'b0, fa[i % 3], 32'h0, d);
      `CHK(d, {28'h0, fl[i % 3]})
      fl[i % 3] &= ~r[15:12];
      bus(1'b1, fa[i % 3], {28'h0, r[15:12]}, d);
      chk();
    end
    $display("random test done");
    ctl = 9'h083;
    bus(1'b1, intid_pkg::ADDR_CTRL, 32'h3, d);
    en[0] = 4'h1;
    bus(1'b1, intid_pkg::ADDR_EN0, 32'h1, d);
    pulse(12'h001);
    chk();
    bus(1'b1, intid_pkg::ADDR_CLKCTL, 32'hffffffff, d);
    bus(1'b0, intid_pkg::ADDR_CLKCTL, 32'h0, d);
    `CHK(d, 32'hef)
    `CHK(clkctl, 8'hef)
    `CHK(stop, 1'b0)
    $display("stop test done");
    reset_dut();
    results();
  end
  initial
  begin
    repeat (6000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
